// File: ebw_dev_model.sv
// Pin-level model of the byte-wide EEPROM that the host drives
`timescale 1ns/100ps
`default_nettype none
module ebw_dev_model #(
  parameter int WC_NS = 1000
) (
  input  wire logic       ce_n_i,
  input  wire logic       oe_n_i,
  input  wire logic       oe_hv_i,
  input  wire logic       we_n_i,
  input  wire logic [8:0] addr_i,
  input  wire logic [7:0] din_i,
  output logic      [7:0] dq_o,
  output logic            dq_en_o
);
  logic [7:0] mem [512];
  logic [8:0] wa = '0;
  logic [7:0] wd = '0;
  logic       busy = 1'b0;
  logic       act;
  realtime    t_fall = 0;
  initial foreach (mem[i]) mem[i] = 8'hff;
  // Drives only while selected and gated low; erase level counts as high
  assign dq_en_o = !ce_n_i && !oe_n_i && !oe_hv_i;
  // Inverted top bit at the last address until the internal cycle ends
  assign dq_o = (busy && addr_i == wa) ? {~wd[7], wd[6:0]} : mem[addr_i];
  assign act = !ce_n_i && !we_n_i;
  // Address taken when the later of select and strobe falls
  always @(posedge act)
  begin
    t_fall = $realtime;
    if (!busy) wa = addr_i;
  end
  // Data taken on the first rise; short pulses count as noise
  always @(negedge act)
    if (($realtime - t_fall) > 20.0 && (oe_n_i || oe_hv_i) && !busy)
    begin
      if (oe_hv_i)
      begin
        if (din_i == 8'hff) foreach (mem[i]) mem[i] = 8'hff;
      end
      else
      begin
        wd = din_i;
        busy = 1'b1;
        #(WC_NS);
        mem[wa] = wd;
        busy = 1'b0;
      end
    end
endmodule
`default_nettype wire

// File: ebw_host.sv
// Host controller driving a byte-wide parallel EEPROM through its pins
`timescale 1ns/100ps
`default_nettype none
module ebw_host #(
  parameter int unsigned WC_CYC    = ebw_pkg::C_WC,
  parameter int unsigned ER_WP_CYC = ebw_pkg::C_ER_WP
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      req_valid_i,
  input  wire ebw_pkg::ebw_req_t         req_i,
  output logic                           req_ready_o,
  output logic                           rsp_valid_o,
  output logic [ebw_pkg::DATA_W-1:0]     rsp_data_o,
  output logic                           rsp_timeout_o,
  output ebw_pkg::ebw_pins_t             pins_o,
  input  wire logic [ebw_pkg::DATA_W-1:0] data_lines_i
);
  typedef enum logic [3:0] {
    S_IDLE, S_RD_ACC, S_RD_END, S_WR_SU, S_WR_LOW, S_WR_HOLD,
    S_ER_SU, S_ER_LOW, S_ER_HOLD, S_POLL_RD, S_POLL_GAP
  } ebw_state_t;

  localparam int unsigned CW = ebw_pkg::CNT_W;

  logic              rst_s1_r;
  logic              rst_s2_r;
  logic [ebw_pkg::DATA_W-1:0] din_s1_r;
  logic [ebw_pkg::DATA_W-1:0] din_s2_r;
  ebw_state_t        st_r;
  logic [CW-1:0]     cnt_r;
  logic [CW-1:0]     wc_r;
  logic [ebw_pkg::DATA_W-1:0] wdata_r;
  ebw_pkg::ebw_pins_t pins_r;
  logic [7:0]        wlow_cnt_r;
  logic              busy_r;

  function automatic logic [CW-1:0] cyc(input int unsigned n);
    return CW'(n - 1);
  endfunction

  // Reset release through two flops
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // Data pins come from outside the clock domain
  always_ff @(posedge mclk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
    end
    else
    begin
      din_s1_r <= data_lines_i;
      din_s2_r <= din_s1_r;
    end
  end

  // Main sequencer; pins only change on state moves so strobes stay clean
  always_ff @(posedge mclk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      st_r          <= S_IDLE;
      cnt_r         <= '0;
      wdata_r       <= 8'h00;
      rsp_valid_o   <= 1'b0;
      rsp_data_o    <= 8'h00;
      rsp_timeout_o <= 1'b0;
      // Idle pins inhibit writes: select, gate and strobe all high
      pins_r        <= '{ce_n: 1'b1, oe_n: 1'b1, oe_hv: 1'b0, we_n: 1'b1,
                         addr: '0, dout: 8'h00, doe_n: 8'hff}; // RL13 RL3
    end
    else
    begin
      rsp_valid_o <= 1'b0;
      if (cnt_r != '0)
        cnt_r <= cnt_r - 1'b1;
      case (st_r)
        S_IDLE:
          if (req_valid_i && !busy_r)
          begin
            pins_r.addr  <= req_i.addr;
            wdata_r      <= req_i.data;
            rsp_timeout_o <= 1'b0;
            case (req_i.cmd)
              ebw_pkg::EBW_CMD_READ, ebw_pkg::EBW_CMD_POLL:
              begin
                // Drive our data lines off before the device may drive
                pins_r.doe_n <= 8'hff;
                pins_r.ce_n  <= 1'b0; // RL1
                pins_r.oe_n  <= 1'b0; // RL1
                cnt_r        <= cyc(ebw_pkg::C_ACC + 2);
                st_r         <= (req_i.cmd == ebw_pkg::EBW_CMD_POLL) ? S_POLL_RD : S_RD_ACC;
              end
              ebw_pkg::EBW_CMD_WRITE:
              begin
                // Gate high and data driven before the strobe falls
                pins_r.oe_n  <= 1'b1; // RL4
                pins_r.dout  <= req_i.data;
                pins_r.doe_n <= 8'h00;
                pins_r.ce_n  <= 1'b0;
                cnt_r        <= cyc(ebw_pkg::C_AS);
                st_r         <= S_WR_SU;
              end
              default:
              begin
                // Erase level on the gate first, data all high
                pins_r.oe_hv <= 1'b1; // RL8
                pins_r.oe_n  <= 1'b1;
                pins_r.dout  <= 8'hff; // RL9
                pins_r.doe_n <= 8'h00;
                cnt_r        <= cyc(ebw_pkg::C_ER_SU);
                st_r         <= S_ER_SU;
              end
            endcase
          end
        S_RD_ACC, S_POLL_RD:
          if (cnt_r == '0)
          begin
            rsp_data_o  <= din_s2_r;
            // Poll repeats until top bit reads true value or the write-cycle timer wc_r reaches zero
            if (st_r == S_POLL_RD && din_s2_r[7] != wdata_r[7] && wc_r != '0) // RL10 RL11
            begin
              st_r <= S_POLL_GAP;
            end
            else
            begin
              rsp_valid_o   <= 1'b1;
              rsp_timeout_o <= (st_r == S_POLL_RD) && (din_s2_r[7] != wdata_r[7]);
              st_r          <= S_RD_END;
            end
            pins_r.ce_n <= 1'b1; // RL2
            pins_r.oe_n <= 1'b1; // RL2
            cnt_r       <= cyc(ebw_pkg::C_DF);
          end
        S_POLL_GAP:
          if (cnt_r == '0)
          begin
            pins_r.ce_n <= 1'b0;
            pins_r.oe_n <= 1'b0;
            cnt_r       <= cyc(ebw_pkg::C_ACC + 2);
            st_r        <= S_POLL_RD;
          end
        S_RD_END:
          if (cnt_r == '0)
            st_r <= S_IDLE;
        S_WR_SU:
          if (cnt_r == '0)
          begin
            pins_r.we_n <= 1'b0; // RL5
            cnt_r       <= cyc(ebw_pkg::C_WP); // RL12
            st_r        <= S_WR_LOW;
          end
        S_WR_LOW:
          if (cnt_r == '0)
          begin
            pins_r.we_n <= 1'b1; // RL6
            cnt_r       <= cyc(ebw_pkg::C_DH > ebw_pkg::C_WPH ? ebw_pkg::C_DH : ebw_pkg::C_WPH);
            st_r        <= S_WR_HOLD;
          end
        S_WR_HOLD, S_ER_HOLD:
          if (cnt_r == '0)
          begin
            pins_r.ce_n  <= 1'b1;
            pins_r.oe_hv <= 1'b0;
            pins_r.doe_n <= 8'hff;
            rsp_valid_o  <= 1'b1;
            st_r         <= S_IDLE;
          end
        S_ER_SU:
          if (cnt_r == '0)
          begin
            pins_r.ce_n <= 1'b0;
            pins_r.we_n <= 1'b0; // RL8
            cnt_r       <= CW'(ER_WP_CYC - 1);
            st_r        <= S_ER_LOW;
          end
        S_ER_LOW:
          if (cnt_r == '0)
          begin
            pins_r.we_n <= 1'b1;
            cnt_r       <= cyc(ebw_pkg::C_ER_HD);
            st_r        <= S_ER_HOLD;
          end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  // Write-cycle timer: no new write or erase until the device finished
  always_ff @(posedge mclk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
      wc_r <= '0;
    else if (st_r == S_WR_LOW && cnt_r == '0)
      wc_r <= CW'(WC_CYC); // RL7
    else if (wc_r != '0)
      wc_r <= wc_r - 1'b1;
  end

  // Reads and polls may run during the write cycle; writes wait
  assign busy_r = (wc_r != '0) && req_valid_i && (req_i.cmd == ebw_pkg::EBW_CMD_WRITE
                  || req_i.cmd == ebw_pkg::EBW_CMD_ERASE); // RL14

  always_ff @(posedge mclk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
      req_ready_o <= 1'b0;
    else
      req_ready_o <= (st_r == S_IDLE) && !(req_valid_i && !busy_r);
  end

  assign pins_o = pins_r;

  // Strobe low-time count for the width check; saturates so long erase strobes never wrap
  always_ff @(posedge mclk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
      wlow_cnt_r <= 8'h00;
    else if (pins_r.we_n)
      wlow_cnt_r <= 8'h00;
    else if (wlow_cnt_r != 8'hff)
      wlow_cnt_r <= wlow_cnt_r + 8'h01;
  end

  // Checks
  wr_gate_high_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_r)
    !pins_r.we_n && !pins_r.oe_hv |-> pins_r.oe_n && !pins_r.ce_n) // RL4
    else $error("strobe low without gate high");
  rd_no_drive_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_r)
    !pins_r.oe_n |-> pins_r.doe_n == 8'hff) // RL1
    else $error("host drives data during read");
  strobe_width_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_r)
    $rose(pins_r.we_n) |-> wlow_cnt_r >= 8'(ebw_pkg::C_WP)) // RL12
    else $error("write strobe too short");
  erase_data_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_r)
    pins_r.oe_hv && !pins_r.we_n |-> pins_r.dout == 8'hff && pins_r.doe_n == 8'h00) // RL9
    else $error("erase without data high");
  erase_order_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_r)
    $rose(pins_r.oe_hv) |-> pins_r.we_n [*8]) // RL8
    else $error("erase level not first");
  no_write_busy_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_r)
    wc_r != '0 && st_r == S_IDLE |=> !(st_r == S_WR_SU || st_r == S_ER_SU)) // RL14
    else $error("write started during write cycle");
  rd_release_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_r)
    rsp_valid_o && st_r == S_RD_END |-> pins_r.oe_n && pins_r.ce_n) // RL2
    else $error("read not ended");
  standby_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_r)
    pins_r.ce_n |-> pins_r.we_n) // RL3
    else $error("strobe low in standby");
  cov_write_c: cover property (@(posedge mclk_i) disable iff (!rst_s2_r) st_r == S_WR_HOLD);
  cov_erase_c: cover property (@(posedge mclk_i) disable iff (!rst_s2_r) st_r == S_ER_LOW);
  cov_poll_c:  cover property (@(posedge mclk_i) disable iff (!rst_s2_r) st_r == S_POLL_GAP);
endmodule
`default_nettype wire

// File: ebw_host_test.sv
// Self-checking bench for the EEPROM host controller
`timescale 1ns/100ps
`default_nettype none
module ebw_host_test;
  localparam int WC = 200;
  logic                  mclk_i = 1'b0;
  logic                  rst_n_i = 1'b0;
  logic                  req_valid_i = 1'b0;
  ebw_pkg::ebw_req_t     req_i = '0;
  logic                  req_ready_o, rsp_valid_o, rsp_timeout_o;
  logic [7:0]            rsp_data_o, dq, dl, dl_last = 8'h00;
  logic                  dq_en;
  ebw_pkg::ebw_pins_t    pins_o;
  int                    err_total = 0;
  int                    samples_checked = 0;
  int                    cyc, wlow = 0;
  always #4 mclk_i = ~mclk_i;
  ebw_host #(.WC_CYC(WC), .ER_WP_CYC(100)) u_ebw_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_timeout_o(rsp_timeout_o),
    .pins_o(pins_o), .data_lines_i(dl));
  ebw_dev_model #(.WC_NS(1000)) u_ebw_dev_model (.ce_n_i(pins_o.ce_n), .oe_n_i(pins_o.oe_n),
    .oe_hv_i(pins_o.oe_hv), .we_n_i(pins_o.we_n), .addr_i(pins_o.addr), .din_i(pins_o.dout),
    .dq_o(dq), .dq_en_o(dq_en));
  // Undriven lines show the inverse of their last level, never a held value
  assign dl = (~pins_o.doe_n & pins_o.dout) | (pins_o.doe_n & (dq_en ? dq : ~dl_last));
  always @(posedge mclk_i) dl_last <= dl;
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One request held until its response, then dropped; bounded wait
  task automatic do_req(input ebw_pkg::ebw_cmd_t c, input logic [8:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    req_i = '{cmd: c, addr: a, data: d};
    req_valid_i = 1'b1;
    for (cyc = 0; cyc < 5000 && rsp_valid_o !== 1'b1; cyc++) @(negedge mclk_i);
    req_valid_i = 1'b0;
    if (cyc >= 5000)
    begin
      err_total++;
      test_done();
    end
  endtask
  // Pin watch: write combination, strobe width, erase data, bus contention
  always @(negedge mclk_i)
    if (rst_n_i)
    begin
      if (!pins_o.ce_n && !pins_o.we_n) chk(pins_o.oe_n | pins_o.oe_hv, 1);
      if (!pins_o.we_n && pins_o.oe_hv) chk({pins_o.dout, pins_o.doe_n}, 16'hff00);
      if (dq_en) chk(pins_o.doe_n, 8'hff);
      if (pins_o.we_n && wlow > 0) chk(wlow > 2, 1);
      wlow = pins_o.we_n ? 0 : wlow + 1;
    end
  task automatic sc_idle();
    chk({pins_o.ce_n, pins_o.oe_n, pins_o.we_n, pins_o.oe_hv, pins_o.doe_n}, 12'heff);
  endtask
  task automatic sc_write_poll();
    do_req(ebw_pkg::EBW_CMD_WRITE, 9'h1a5, 8'h5a);
    do_req(ebw_pkg::EBW_CMD_READ, 9'h1a5, 8'h00);
    chk(rsp_data_o, 8'hda);
    do_req(ebw_pkg::EBW_CMD_POLL, 9'h1a5, 8'h5a);
    chk({rsp_timeout_o, rsp_data_o}, 9'h05a);
    do_req(ebw_pkg::EBW_CMD_READ, 9'h1a5, 8'h00);
    chk(rsp_data_o, 8'h5a);
  endtask
  task automatic sc_back_to_back();
    do_req(ebw_pkg::EBW_CMD_WRITE, 9'h000, 8'h81);
    do_req(ebw_pkg::EBW_CMD_WRITE, 9'h1ff, 8'h7e);
    chk(cyc >= WC - 20, 1);
    do_req(ebw_pkg::EBW_CMD_READ, 9'h1ff, 8'h00);
    chk(rsp_data_o, 8'hfe);
    do_req(ebw_pkg::EBW_CMD_POLL, 9'h1ff, 8'h7e);
    chk({rsp_timeout_o, rsp_data_o}, 9'h07e);
    do_req(ebw_pkg::EBW_CMD_READ, 9'h000, 8'h00);
    chk(rsp_data_o, 8'h81);
  endtask
  task automatic sc_erase();
    do_req(ebw_pkg::EBW_CMD_ERASE, 9'h0c3, 8'hff);
    do_req(ebw_pkg::EBW_CMD_READ, 9'h000, 8'h00);
    chk(rsp_data_o, 8'hff);
    do_req(ebw_pkg::EBW_CMD_READ, 9'h1ff, 8'h00);
    chk(rsp_data_o, 8'hff);
  endtask
  initial
  begin
    repeat (20) @(negedge mclk_i);
    sc_idle();
    rst_n_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk(req_ready_o, 1);
    sc_write_poll();
    sc_back_to_back();
    sc_erase();
    test_done();
  end
endmodule
`default_nettype wire

// File: ebw_pkg.sv
// Package for the parallel EEPROM byte-write host controller
//
// Behaviour
// (RL1) Read data is valid only while chip select and output gate are both low.
// (RL2) Raising chip select or output gate ends a read; device floats its data.
// (RL3) Chip select high means standby; no write is accepted then.
// (RL4) Write only with chip select and strobe low, output gate held high.
// (RL5) Device latches address on the later falling edge of select or strobe.
// (RL6) Device latches data on the earlier rising edge of select or strobe.
// (RL7) Internal erase-then-program finishes within the 10 ms write cycle time.
// (RL8) Chip erase: raise output gate to erase level first, then select and strobe low.
// (RL9) For chip erase all eight data lines are driven high beforehand.
// (RL10) During internal write, reading the last address gives inverted top data bit.
// (RL11) After the internal write the top data bit reads true, ending polling.
// (RL12) Strobe pulses of 20 ns or less are ignored by the device.
// (RL13) Writes are inhibited while output gate low or select or strobe high.
// (RL14) No new byte write is taken until the internal cycle completes.
`default_nettype none
package ebw_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  // Timing figures in their printed units, and derived cycle counts
  localparam int unsigned T_AS_NS   = 10;
  localparam int unsigned T_WP_NS   = 150;
  localparam int unsigned T_WPH_NS  = 50;
  localparam int unsigned T_DS_NS   = 100;
  localparam int unsigned T_DH_NS   = 20;
  localparam int unsigned T_ACC_NS  = 250;
  localparam int unsigned T_DF_NS   = 80;
  localparam int unsigned T_ER_SU_NS = 500;
  localparam int unsigned T_ER_WP_MS = 10;
  localparam int unsigned T_ER_HD_US = 8;
  localparam int unsigned T_WC_MS   = 10;
  // Worked in 64 bits: millisecond figures in picoseconds overflow 32 bits
  function automatic int unsigned ns_cyc(input int unsigned ns);
    longint unsigned c;
    c = (64'(ns) * 64'd1000 + 64'(CLK_PERIOD_PS) - 64'd1) / 64'(CLK_PERIOD_PS);
    return (c == 64'd0) ? 32'd1 : 32'(c);
  endfunction
  localparam int unsigned C_AS    = ns_cyc(T_AS_NS);
  localparam int unsigned C_WP    = ns_cyc(T_WP_NS);
  localparam int unsigned C_WPH   = ns_cyc(T_WPH_NS);
  localparam int unsigned C_DH    = ns_cyc(T_DH_NS);
  localparam int unsigned C_ACC   = ns_cyc(T_ACC_NS);
  localparam int unsigned C_DF    = ns_cyc(T_DF_NS);
  localparam int unsigned C_ER_SU = ns_cyc(T_ER_SU_NS);
  localparam int unsigned C_ER_HD = ns_cyc(T_ER_HD_US * 1000);
  localparam int unsigned C_ER_WP = ns_cyc(T_ER_WP_MS * 1000000);
  localparam int unsigned C_WC    = ns_cyc(T_WC_MS * 1000000);
  localparam int unsigned CNT_W   = 24;
  // Command encoding on the user port
  typedef enum logic [1:0] {EBW_CMD_READ, EBW_CMD_WRITE, EBW_CMD_ERASE, EBW_CMD_POLL} ebw_cmd_t;
  typedef struct packed {
    ebw_cmd_t            cmd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } ebw_req_t;
  // Device pins as driven by the host; out enables are low while driving
  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                oe_hv;
    logic                we_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dout;
    logic [DATA_W-1:0]   doe_n;
  } ebw_pins_t;
endpackage
`default_nettype wire
